/* File: rtl/isa_params.svh */
// Constants shared by both ends of the ISA slave port link
`ifndef ISA_PARAMS_SVH
`define ISA_PARAMS_SVH
`define CLK_PERIOD_NS 40
`define OSC_PERIOD_NS 50
`define RESET_MIN_OSC_PERIODS 10
`define RESET_HOLD_CYCLES \
  ((`RESET_MIN_OSC_PERIODS * `OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PINS_IDLE 40'hFE00000000
`define IO_WIN_HI 9
`define IO_WIN_LO 4
`define DREG_FLAGS 3'h0
`define DREG_MASK 3'h1
`define DREG_CFG 3'h2
`define DREG_STAT 3'h3
`define CFG_WORD_IO_BIT 0
`define CFG_IRQ_SEL_LSB 4
`define CFG_IRQ_EN_BIT 7
`define CFG_RESET 8'h00
`define MASK_RESET 6'h00
`define FLAG_BABBLE 0
`define FLAG_MISSED 1
`define FLAG_MEM_ERR 2
`define FLAG_RX_DONE 3
`define FLAG_INIT_DONE 4
`define FLAG_TX_START 5
`define HREG_CTRL 8'h00
`define HREG_ADDR 8'h04
`define HREG_WDATA 8'h08
`define HREG_STATUS 8'h0C
`define HREG_RDATA 8'h10
`define CTRL_WORD_BIT 2
`define CTRL_REF_BIT 3
`define CTRL_GO_BIT 4
`define CTRL_RST_BIT 5
`define ADDR_SETUP_CYCLES 8'd6
`define STROBE_MIN_CYCLES 8'd8
`define RECOVERY_CYCLES 8'd3
`endif

/* File: rtl/isa_pkg.sv */
// Types shared by both ends of the ISA slave port link
package isa_pkg;
  `include "isa_params.svh"

  typedef logic [5:0] flags_t;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_BUSY = 2'b01,
    D_DONE = 2'b11
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ADDR = 2'b01,
    H_STROBE = 2'b11,
    H_RECOV = 2'b10
  } host_state_t;

  typedef struct packed {
    logic [39:0] meta;
    logic [39:0] pins;
    dev_state_t state;
    logic rd;
    logic mem;
    logic sbhe_prev;
    logic sbhe_seen;
    logic [3:0] off;
    flags_t flags;
    flags_t mask;
    logic [7:0] cfg;
    logic [15:0] sd_o;
    logic sd_oe;
    logic rdy_oe;
    logic cs16_oe;
    logic [7:0] irq_o;
    logic [7:0] irq_oe;
    logic mem_rd;
    logic mem_wr;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic irq_pending;
  } dev_st_t;

  typedef struct packed {
    logic [25:0] meta;
    logic [25:0] pins;
    host_state_t state;
    logic [7:0] cnt;
    logic [7:0] rst_cnt;
    logic [1:0] cmd;
    logic word;
    logic refr;
    logic split;
    logic half;
    logic done;
    logic cs16_seen;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] sa;
    logic aen;
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;
    logic ref_n;
    logic sbhe_n;
    logic isa_rst;
    logic [15:0] sd_o;
    logic sd_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } host_st_t;
endpackage : isa_pkg

/* File: rtl/isa_if.sv */
// ISA bus wires between the host end and the slave end
`timescale 1ns/1ps
interface isa_if;
  logic [15:0] sa;
  logic aen, ior_n, iow_n, memr_n, memw_n, ref_n, sbhe_n, isa_rst;
  logic [15:0] host_sd_o;
  logic host_sd_oe;
  logic [15:0] dev_sd_o;
  logic dev_sd_oe;
  logic rdy_o, rdy_oe, cs16_o, cs16_oe;
  logic [7:0] irq_o;
  logic [7:0] irq_oe;
  logic [15:0] sd;
  logic iochrdy;
  logic iocs16_n;
  logic [7:0] irq;

  // Resolved levels: pull-ups on data and open-drain lines, pull-downs on requests
  assign sd = dev_sd_oe ? dev_sd_o : (host_sd_oe ? host_sd_o : 16'hFFFF);
  assign iochrdy = !(rdy_oe && !rdy_o);
  assign iocs16_n = !(cs16_oe && !cs16_o);
  assign irq = irq_oe & irq_o;

  modport device (
    input sa, aen, ior_n, iow_n, memr_n, memw_n, ref_n, sbhe_n, isa_rst, sd,
    output dev_sd_o, dev_sd_oe, rdy_o, rdy_oe, cs16_o, cs16_oe, irq_o, irq_oe
  );
  modport host (
    output sa, aen, ior_n, iow_n, memr_n, memw_n, ref_n, sbhe_n, isa_rst,
    output host_sd_o, host_sd_oe,
    input sd, iochrdy, iocs16_n, irq
  );
endinterface : isa_if

/* File: rtl/isa_slave_end.sv */
// ISA slave end: I/O window registers, memory port, interrupt request lines
// Summary of operation
// - Host holds AEN low for I/O cycles
// - I/O read needs AEN low and window hit
// - Qualified I/O read returns addressed register
// - Qualified I/O write latches bus data
// - IOCHRDY rises only with data valid/captured
// - IOCS16 low on word-capable window addresses
// - Host splits I/O word without IOCS16 into bytes
// - IOCS16 decoded from SA4-9, AEN, config bit 0 and SBHE seen
// - Config bit 0 clear gives byte-only I/O
// - Any set unmasked status flag raises interrupt
// - Each flag has its own suppressing mask
// - Request selectable on eight ISA IRQ lines
// - Low memory read strobe means read request
// - Low memory write strobe means write request
// - Memory read ignored while refresh active
// - Drive data bus only on slave reads
// - Byte-only until a falling SBHE edge
// - Host holds RESET ten oscillator periods
`timescale 1ns/1ps
module isa_slave_end #(
  parameter logic [9:0] IO_BASE = 10'h300,
  parameter logic [3:0] MEM_BASE = 4'hD
) (
  input wire logic clk,
  input wire logic sys_rst,
  isa_if.device bus,
  input wire isa_pkg::flags_t flag_events,
  input wire logic [15:0] mem_rdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic irq_pending
);
  import isa_pkg::*;

  dev_st_t s;
  dev_st_t n;
  logic [39:0] pin_vec;
  logic aen, ior_n, iow_n, memr_n, memw_n, ref_n, sbhe_n, isa_rst;
  logic [15:0] sa;
  logic [15:0] sd;
  logic io_sel;
  logic mem_hit;
  logic word_ok;
  logic pend;
  flags_t clr;
  logic [7:0] rbyte;
  logic [7:0] line;

  assign pin_vec = {bus.aen, bus.ior_n, bus.iow_n, bus.memr_n, bus.memw_n,
                    bus.ref_n, bus.sbhe_n, bus.isa_rst, bus.sa, bus.sd};
  assign {aen, ior_n, iow_n, memr_n, memw_n, ref_n, sbhe_n, isa_rst, sa, sd} = s.pins;

  // Window hit from address and AEN alone; word capability also needs config bit 0 and a seen SBHE fall
  assign io_sel = !aen && (sa[`IO_WIN_HI:`IO_WIN_LO] == IO_BASE[`IO_WIN_HI:`IO_WIN_LO]);
  assign mem_hit = (sa[15:12] == MEM_BASE);
  assign word_ok = io_sel && s.cfg[`CFG_WORD_IO_BIT] && s.sbhe_seen;
  assign pend = |(s.flags & ~s.mask);
  assign line = 8'h01 << s.cfg[`CFG_IRQ_SEL_LSB +: 3];

  always_comb begin
    n = s;
    clr = '0;
    rbyte = 8'h00;
    n.meta = pin_vec;
    n.pins = s.meta;
    n.mem_rd = 1'b0;
    n.mem_wr = 1'b0;
    n.sbhe_prev = sbhe_n;
    if (s.sbhe_prev && !sbhe_n) begin
      n.sbhe_seen = 1'b1;
    end
    n.cs16_oe = word_ok;
    case (s.off[3:1])
      `DREG_FLAGS: begin
        rbyte = {2'b00, s.flags};
      end
      `DREG_MASK: begin
        rbyte = {2'b00, s.mask};
      end
      `DREG_CFG: begin
        rbyte = s.cfg;
      end
      `DREG_STAT: begin
        rbyte = {5'h00, s.irq_pending, s.sbhe_seen, s.cfg[`CFG_WORD_IO_BIT]};
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase
    case (s.state)
      D_IDLE: begin
        n.sd_oe = 1'b0;
        n.rdy_oe = 1'b0;
        n.off = sa[3:0];
        if (io_sel && !ior_n) begin
          n.state = D_BUSY;
          n.rd = 1'b1;
          n.mem = 1'b0;
          n.rdy_oe = 1'b1;
        end else if (io_sel && !iow_n) begin
          n.state = D_BUSY;
          n.rd = 1'b0;
          n.mem = 1'b0;
          n.rdy_oe = 1'b1;
        end else if (mem_hit && !memr_n && ref_n) begin
          n.state = D_BUSY;
          n.rd = 1'b1;
          n.mem = 1'b1;
          n.rdy_oe = 1'b1;
          n.mem_rd = 1'b1;
          n.mem_addr = sa;
        end else if (mem_hit && !memw_n) begin
          n.state = D_BUSY;
          n.rd = 1'b0;
          n.mem = 1'b1;
          n.rdy_oe = 1'b1;
          n.mem_wr = 1'b1;
          n.mem_addr = sa;
          n.mem_wdata = sd;
        end
      end
      D_BUSY: begin
        n.state = D_DONE;
        n.rdy_oe = 1'b0;
        if (s.rd) begin
          n.sd_oe = 1'b1;
          if (s.mem) begin
            n.sd_o = mem_rdata;
          end else begin
            n.sd_o = {8'h00, s.off[0] ? 8'h00 : rbyte};
          end
        end else if (!s.mem && !s.off[0]) begin
          case (s.off[3:1])
            `DREG_FLAGS: begin
              clr = sd[5:0];
            end
            `DREG_MASK: begin
              n.mask = sd[5:0];
            end
            `DREG_CFG: begin
              n.cfg = sd[7:0];
            end
            default: begin
              n.cfg = s.cfg;
            end
          endcase
        end
      end
      D_DONE: begin
        if (ior_n && iow_n && memr_n && memw_n) begin
          n.state = D_IDLE;
          n.sd_oe = 1'b0;
        end
      end
      default: begin
        n.state = D_IDLE;
      end
    endcase
    n.flags = (s.flags & ~clr) | flag_events;
    n.irq_pending = pend;
    n.irq_o = pend ? line : 8'h00;
    n.irq_oe = s.cfg[`CFG_IRQ_EN_BIT] ? line : 8'h00;
    if (sys_rst || isa_rst) begin
      n = '0;
      n.meta = sys_rst ? `PINS_IDLE : pin_vec;
      n.pins = sys_rst ? `PINS_IDLE : s.meta;
      n.state = D_IDLE;
      n.sbhe_prev = 1'b1;
      n.cfg = `CFG_RESET;
      n.mask = `MASK_RESET;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  assign bus.dev_sd_o = s.sd_o;
  assign bus.dev_sd_oe = s.sd_oe;
  assign bus.rdy_o = 1'b0;
  assign bus.rdy_oe = s.rdy_oe;
  assign bus.cs16_o = 1'b0;
  assign bus.cs16_oe = s.cs16_oe;
  assign bus.irq_o = s.irq_o;
  assign bus.irq_oe = s.irq_oe;
  assign mem_rd = s.mem_rd;
  assign mem_wr = s.mem_wr;
  assign mem_addr = s.mem_addr;
  assign mem_wdata = s.mem_wdata;
  assign irq_pending = s.irq_pending;
endmodule : isa_slave_end

/* File: rtl/isa_host_end.sv */
// ISA host end: APB command registers driving ISA I/O and memory cycles
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module isa_host_end (
  input wire logic clk,
  input wire logic sys_rst,
  isa_if.host bus,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import isa_pkg::*;

  host_st_t s;
  host_st_t n;
  logic [25:0] pin_vec;
  logic iochrdy;
  logic iocs16_n;
  logic [7:0] irq;
  logic [15:0] sd;
  logic acc;
  logic idle;

  assign pin_vec = {bus.iochrdy, bus.iocs16_n, bus.irq, bus.sd};
  assign {iochrdy, iocs16_n, irq, sd} = s.pins;
  assign acc = psel && penable && s.pready;
  assign idle = (s.state == H_IDLE) && (s.rst_cnt == 8'h00);

  always_comb begin
    n = s;
    n.meta = pin_vec;
    n.pins = s.meta;
    n.pready = psel && penable && !s.pready;
    n.pslverr = 1'b0;
    if (n.pready) begin
      case (paddr)
        `HREG_CTRL: n.prdata = {28'h0000000, s.refr, s.word, s.cmd};
        `HREG_ADDR: n.prdata = {16'h0000, s.addr};
        `HREG_WDATA: n.prdata = {16'h0000, s.wdata};
        `HREG_STATUS: n.prdata = {16'h0000, irq, 4'h0, s.isa_rst, s.cs16_seen, s.done, !idle};
        `HREG_RDATA: n.prdata = {16'h0000, s.rdata};
        default: begin
          n.prdata = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (s.rst_cnt != 8'h00) begin
      n.rst_cnt = s.rst_cnt - 8'h01;
    end
    n.isa_rst = (s.rst_cnt != 8'h00);
    if (acc && !pwrite && paddr == `HREG_STATUS) begin
      n.done = 1'b0;
    end
    if (acc && pwrite) begin
      case (paddr)
        `HREG_ADDR: n.addr = pwdata[15:0];
        `HREG_WDATA: n.wdata = pwdata[15:0];
        `HREG_CTRL: begin
          if (idle && pwdata[`CTRL_RST_BIT]) begin
            n.rst_cnt = 8'(`RESET_HOLD_CYCLES);
          end else if (idle && pwdata[`CTRL_GO_BIT]) begin
            n.cmd = pwdata[1:0];
            n.word = pwdata[`CTRL_WORD_BIT];
            n.refr = pwdata[`CTRL_REF_BIT];
            n.state = H_ADDR;
            n.cnt = 8'h00;
            n.split = 1'b0;
            n.half = 1'b0;
            n.cs16_seen = 1'b0;
            n.sa = s.addr;
            n.aen = 1'b0;
            n.sbhe_n = !pwdata[`CTRL_WORD_BIT];
            n.ref_n = !pwdata[`CTRL_REF_BIT];
            n.sd_o = s.wdata;
            n.sd_oe = pwdata[0];
          end
        end
        default: n.addr = s.addr;
      endcase
    end
    case (s.state)
      H_IDLE: begin
        n.cnt = 8'h00;
      end
      H_ADDR: begin
        n.cnt = s.cnt + 8'h01;
        if (s.cnt == `ADDR_SETUP_CYCLES - 8'h01) begin
          n.cnt = 8'h00;
          n.state = H_STROBE;
          if (!s.cmd[1] && !iocs16_n) begin
            n.cs16_seen = 1'b1;
          end
          if (!s.cmd[1] && s.word && !s.split && iocs16_n) begin
            n.split = 1'b1;
            n.sbhe_n = 1'b1;
          end
          n.ior_n = (s.cmd != 2'd0);
          n.iow_n = (s.cmd != 2'd1);
          n.memr_n = (s.cmd != 2'd2);
          n.memw_n = (s.cmd != 2'd3);
        end
      end
      H_STROBE: begin
        if (s.cnt != `STROBE_MIN_CYCLES) begin
          n.cnt = s.cnt + 8'h01;
        end else if (iochrdy) begin
          if (!s.split) begin
            n.rdata = sd;
          end else if (s.half) begin
            n.rdata[15:8] = sd[7:0];
          end else begin
            n.rdata = {8'h00, sd[7:0]};
          end
          n.ior_n = 1'b1;
          n.iow_n = 1'b1;
          n.memr_n = 1'b1;
          n.memw_n = 1'b1;
          n.cnt = 8'h00;
          n.state = H_RECOV;
        end
      end
      H_RECOV: begin
        n.cnt = s.cnt + 8'h01;
        if (s.cnt == `RECOVERY_CYCLES - 8'h01) begin
          n.cnt = 8'h00;
          if (s.split && !s.half) begin
            n.half = 1'b1;
            n.sa = s.addr + 16'h0001;
            n.sd_o = {8'h00, s.wdata[15:8]};
            n.state = H_ADDR;
          end else begin
            n.state = H_IDLE;
            n.done = 1'b1;
            n.ref_n = 1'b1;
            n.sbhe_n = 1'b1;
            n.sd_oe = 1'b0;
          end
        end
      end
      default: begin
        n.state = H_IDLE;
      end
    endcase
    if (sys_rst) begin
      n = '0;
      n.meta = pin_vec;
      n.pins = s.meta;
      n.state = H_IDLE;
      n.ior_n = 1'b1;
      n.iow_n = 1'b1;
      n.memr_n = 1'b1;
      n.memw_n = 1'b1;
      n.ref_n = 1'b1;
      n.sbhe_n = 1'b1;
      n.rst_cnt = 8'(`RESET_HOLD_CYCLES);
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  assign bus.sa = s.sa;
  assign bus.aen = s.aen;
  assign bus.ior_n = s.ior_n;
  assign bus.iow_n = s.iow_n;
  assign bus.memr_n = s.memr_n;
  assign bus.memw_n = s.memw_n;
  assign bus.ref_n = s.ref_n;
  assign bus.sbhe_n = s.sbhe_n;
  assign bus.isa_rst = s.isa_rst;
  assign bus.host_sd_o = s.sd_o;
  assign bus.host_sd_oe = s.sd_oe;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
endmodule : isa_host_end

/* File: tb/isa_link_assertions.sv */
// Checker for the ISA link between host end and slave end
`timescale 1ns/1ps
module isa_link_assertions #(
  parameter logic [9:0] IO_BASE = 10'h300
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic ref_n,
  input wire logic sbhe_n,
  input wire logic dev_sd_oe,
  input wire logic rdy_oe,
  input wire logic cs16_oe,
  input wire logic [7:0] irq_oe
);
  logic hit;
  logic seen;
  assign hit = !aen && sa[9:4] == IO_BASE[9:4];
  // Remembers a falling high-byte enable since reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seen <= 1'b0;
    end else if ($fell(sbhe_n)) begin
      seen <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ready_pulse: assert property (rdy_oe |=> !rdy_oe)
    else $error("ready hold longer than one cycle");
  a_read_data_valid: assert property ($fell(rdy_oe) && !(ior_n && memr_n) |-> dev_sd_oe)
    else $error("ready released before read data driven");
  a_no_drive_write: assert property (dev_sd_oe |-> iow_n && memw_n)
    else $error("data bus driven during a write");
  a_sd_release: assert property ($rose(ior_n) || $rose(memr_n) |-> ##[1:4] !dev_sd_oe)
    else $error("data bus not released after read");
  a_ready_in_cycle: assert property (rdy_oe |-> !(ior_n && iow_n && memr_n && memw_n))
    else $error("ready pulled outside an access");
  a_io_claim: assert property (rdy_oe && memr_n && memw_n |-> $past(hit, 3))
    else $error("io strobe claimed outside window");
  a_refresh_ignored: assert property (!ref_n && !memr_n |-> !rdy_oe)
    else $error("memory read answered during refresh");
  a_cs16_decode: assert property (cs16_oe |-> $past(hit, 3))
    else $error("word select without window decode");
  a_cs16_after_sbhe: assert property (cs16_oe |-> seen)
    else $error("word select before high byte enable fell");
  a_irq_one_line: assert property ($onehot0(irq_oe))
    else $error("more than one request line driven");
  c_io_write: cover property (rdy_oe && !iow_n);
  c_word_select: cover property (cs16_oe);
  c_irq_line: cover property (|irq_oe);
endmodule : isa_link_assertions

/* File: tb/testbench.sv */
// Testbench joining host end and slave end over the ISA link
`timescale 1ns/1ps
`include "isa_params.svh"
module testbench;
  import isa_pkg::*;
  typedef struct {string nm; logic [31:0] e; logic [31:0] mk; logic er;} note_t;
  typedef struct {logic [15:0] a; logic [15:0] d;} mem_note_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  flags_t flag_events = 6'h00;
  logic [15:0] mem_rdata = 16'h0000;
  logic mem_rd;
  logic mem_wr;
  logic irq_pending;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  int errors = 0;
  int cmp_count = 0;
  int rd_count = 0;
  int seed = 32'hf35f13b4;
  note_t rd_q[$];
  mem_note_t mem_q[$];
  note_t n;
  mem_note_t m;
  logic [31:0] st;
  logic [15:0] a;
  logic [15:0] r;
  int i;
  int k;
  isa_if bus();
  isa_host_end u_isa_host_end (.clk(clk), .sys_rst(sys_rst), .bus(bus), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  isa_slave_end #(.IO_BASE(10'h300), .MEM_BASE(4'hD)) u_isa_slave_end (.clk(clk),
    .sys_rst(sys_rst), .bus(bus), .flag_events(flag_events), .mem_rdata(mem_rdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .irq_pending(irq_pending));
  isa_link_assertions #(.IO_BASE(10'h300)) u_isa_link_assertions (.clk(clk), .sys_rst(sys_rst),
    .sa(bus.sa), .aen(bus.aen), .ior_n(bus.ior_n), .iow_n(bus.iow_n), .memr_n(bus.memr_n),
    .memw_n(bus.memw_n), .ref_n(bus.ref_n), .sbhe_n(bus.sbhe_n), .dev_sd_oe(bus.dev_sd_oe),
    .rdy_oe(bus.rdy_oe), .cs16_oe(bus.cs16_oe), .irq_oe(bus.irq_oe));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
    output logic [31:0] q);
    int j;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    j = 0;
    do begin
      @(posedge clk);
      j++;
    end while (pready !== 1'b1 && j < 50);
    if (pready !== 1'b1) begin
      chk("pready", 1, 0);
      print_verdict();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk,
    input logic er);
    logic [31:0] q;
    rd_q.push_back('{$sformatf("apb read %h", ad), e, mk, er});
    apb(1'b0, ad, 32'h0, q);
  endtask : rd

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, ad, d, q);
  endtask : wr

  // Issues one ISA cycle and polls until the host end reports done
  task automatic isa(input logic [1:0] cmd, input logic [15:0] ad, input logic [15:0] d,
    input logic word, input logic refr);
    int j;
    wr(`HREG_ADDR, {16'h0, ad});
    wr(`HREG_WDATA, {16'h0, d});
    wr(`HREG_CTRL, {27'h0, 1'b1, refr, word, cmd});
    st = 32'h0;
    for (j = 0; j < 40 && st[1] !== 1'b1; j++) begin
      rd_q.push_back('{"poll", 32'h0, 32'h0, 1'b0});
      apb(1'b0, `HREG_STATUS, 32'h0, st);
    end
    if (st[1] !== 1'b1) begin
      chk("done", 1, 0);
      print_verdict();
    end
  endtask : isa

  task automatic io_rd(input logic [15:0] ad, input logic word, input logic [31:0] e,
    input logic [31:0] mk);
    isa(2'd0, ad, 16'h0, word, 1'b0);
    rd(`HREG_RDATA, e, mk, 1'b0);
  endtask : io_rd

  task automatic io_wr(input logic [15:0] ad, input logic [15:0] d);
    isa(2'd1, ad, d, 1'b0, 1'b0);
  endtask : io_wr

  // Result watcher: takes the oldest note when a result appears
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      n = rd_q.pop_front();
      if (n.mk != 32'h0) begin
        chk(n.nm, n.e & n.mk, prdata & n.mk);
        chk("pslverr", {31'h0, n.er}, {31'h0, pslverr});
      end
    end
    if (mem_wr === 1'b1 && mem_q.size() > 0) begin
      m = mem_q.pop_front();
      chk("mem_addr", {16'h0, m.a}, {16'h0, mem_addr});
      chk("mem_wdata", {16'h0, m.d}, {16'h0, mem_wdata});
    end
    if (mem_rd === 1'b1) begin
      rd_count++;
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (`RESET_HOLD_CYCLES + 4) @(posedge clk);
    rd(8'h14, 32'h0, 32'hFFFFFFFF, 1'b1);
    io_rd(16'h304, 1'b0, 32'h00, 32'hFF);
    io_rd(16'h306, 1'b0, 32'h00, 32'hFF);
    io_wr(16'h304, 16'h0001);
    io_rd(16'h304, 1'b0, 32'h01, 32'hFF);
    io_rd(16'h306, 1'b0, 32'h01, 32'hFF);
    io_rd(16'h304, 1'b1, 32'h0001, 32'hFFFF);
    io_rd(16'h304, 1'b1, 32'h0001, 32'hFFFF);
    rd(`HREG_STATUS, 32'h4, 32'h5, 1'b0);
    io_rd(16'h306, 1'b0, 32'h03, 32'hFF);
    io_wr(16'h304, 16'h0000);
    io_rd(16'h306, 1'b1, 32'h0002, 32'hFFFF);
    rd(`HREG_STATUS, 32'h0, 32'h4, 1'b0);
    io_wr(16'h244, 16'h0055);
    io_rd(16'h244, 1'b0, 32'hFF, 32'hFF);
    io_rd(16'h304, 1'b0, 32'h00, 32'hFF);
    for (i = 0; i < 8; i++) begin
      k = i % 6;
      io_wr(16'h304, {8'h0, 1'b1, 3'(i), 4'h0});
      @(posedge clk);
      flag_events <= 6'(1 << k);
      @(posedge clk);
      flag_events <= 6'h00;
      repeat (3) @(posedge clk);
      chk("irq_pending", 1, {31'h0, irq_pending});
      chk("irq lines", 32'(1 << i), {24'h0, bus.irq});
      io_rd(16'h300, 1'b0, 32'(1 << k), 32'hFF);
      io_wr(16'h302, 16'(1 << k));
      chk("irq_pending", 0, {31'h0, irq_pending});
      io_wr(16'h302, 16'h0000);
      chk("irq_pending", 1, {31'h0, irq_pending});
      io_wr(16'h300, 16'(1 << k));
      chk("irq_pending", 0, {31'h0, irq_pending});
      chk("irq lines", 0, {24'h0, bus.irq});
    end
    // Bus reset pulse from the host end clears the slave configuration
    wr(`HREG_CTRL, 32'h00000020);
    rd(`HREG_STATUS, 32'h9, 32'h9, 1'b0);
    repeat (`RESET_HOLD_CYCLES + 4) @(posedge clk);
    rd(`HREG_STATUS, 32'h0, 32'h9, 1'b0);
    io_rd(16'h304, 1'b0, 32'h00, 32'hFF);
    for (i = 0; i < 4; i++) begin
      a = {4'hD, 12'($random(seed))};
      r = 16'($random(seed));
      mem_q.push_back('{a, r});
      isa(2'd3, a, r, 1'b1, 1'b0);
      r = 16'($random(seed));
      mem_rdata <= r;
      isa(2'd2, a, 16'h0, 1'b1, 1'b0);
      rd(`HREG_RDATA, {16'h0, r}, 32'hFFFF, 1'b0);
    end
    chk("mem reads", 4, rd_count);
    isa(2'd2, a, 16'h0, 1'b1, 1'b1);
    rd(`HREG_RDATA, 32'hFFFF, 32'hFFFF, 1'b0);
    chk("mem reads", 4, rd_count);
    print_verdict();
  end
endmodule : testbench
